// ===== logic/sdc_device.sv
// sdc_device: control logic of the single-channel 16-bit converter.
// assumes link pins synchronous to pclk; presetn is power-up, reset_pin_n the hardware reset pin.
//
// Contract
// - initialisation restores defaults; host waits 250 us
// - default code zero or midscale by select pin
// - output holds default until valid code write
// - reset pin low asynchronously forces defaults
// - host releases reset, waits 250 us
// - select pin sampled when reset pin falls; the code keeps the level from the last clock edge before release
// - key 1010 at trigger starts initialisation
// - 24-bit frames, msb first, address then data
// - select falling starts frame, high ignores clock
// - free-running or gated shift clock accepted
// - addressed register loads on select rising edge
// - host holds select for 24 falling edges
// - short frame discarded, state unchanged
// - update mode bit defers output until trigger
// - load trigger copies buffer when triggered mode
// - output code reset 0000h or 8000h
// - writes go to buffer; immediate mode copies
`timescale 1ns/1ps
module sdc_device (
  // clock and power-up reset
  input wire logic pclk,
  input wire logic presetn,
  // hardware reset pin and level select strap
  input wire logic reset_pin_n,
  input wire logic reset_level_select,
  // serial link
  sdc_link_if.device link,
  // converter output and status
  output logic [15:0] output_code,
  output logic ready
);
  // ------------------------------------------------------------
  // reset and level capture
  // ------------------------------------------------------------
  logic rst_n;
  logic level_q;
  logic soft_init_q;
  assign rst_n = presetn & reset_pin_n;
  // the level is caught on the clock while reset is held, so it keeps the pin level from the last edge before release
  always_ff @(posedge pclk) begin
    if (!rst_n) begin
      level_q <= reset_level_select;
    end
  end

  function automatic logic [15:0] default_code(input logic lvl);
    return lvl ? sdc_pkg::CODE_MID : sdc_pkg::CODE_ZERO;
  endfunction

  // ------------------------------------------------------------
  // shift register; link sampled on pclk
  // ------------------------------------------------------------
  logic sel_prev_q;
  logic clk_prev_q;
  logic [23:0] shift_q;
  logic [4:0] count_q;
  logic clk_fall;
  logic sel_rise;
  logic sel_fall;
  assign clk_fall = clk_prev_q & ~link.shift_clock & ~link.frame_select_n;
  assign sel_rise = ~sel_prev_q & link.frame_select_n;
  assign sel_fall = sel_prev_q & ~link.frame_select_n;

  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_prev_q <= 1'b1;
      clk_prev_q <= 1'b0;
    end else begin
      sel_prev_q <= link.frame_select_n;
      clk_prev_q <= link.shift_clock;
    end
  end

  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 24'h00_0000;
      count_q <= 5'h00;
    end else if (soft_init_q || sel_fall || sel_rise) begin
      shift_q <= 24'h00_0000;
      count_q <= 5'h00;
    end else if (clk_fall) begin
      shift_q <= {shift_q[22:0], link.serial_input};
      if (count_q != 5'(sdc_pkg::FRAME_BITS)) begin
        count_q <= count_q + 5'h01;
      end
    end
  end

  // a frame counts only if 24 falling edges came; excess bits keep the last 24
  logic frame_ok;
  logic [7:0] cmd;
  logic [15:0] word;
  assign frame_ok = sel_rise && count_q == 5'(sdc_pkg::FRAME_BITS) && !soft_init_q;
  assign cmd = shift_q[sdc_pkg::ADDR_MSB:sdc_pkg::ADDR_LSB];
  assign word = shift_q[sdc_pkg::DATA_W-1:0];

  // ------------------------------------------------------------
  // register bank
  // ------------------------------------------------------------
  logic mode_q;
  logic [15:0] buffer_q;
  logic [15:0] active_q;
  logic code_valid_q;
  logic buf_wr_q;
  logic out_live_q;
  logic [15:0] code_q;
  logic wr_mode;
  logic wr_trig;
  logic wr_code;
  logic load_now;
  assign wr_mode = frame_ok && cmd == sdc_pkg::ADDR_UPDATE_MODE;
  assign wr_trig = frame_ok && cmd == sdc_pkg::ADDR_TRIGGER;
  assign wr_code = frame_ok && cmd == sdc_pkg::ADDR_OUTPUT_CODE;
  // load trigger is a pulse; nothing stored, so it clears itself
  assign load_now = wr_trig && word[sdc_pkg::LOAD_TRIGGER_BIT] && mode_q;

  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      soft_init_q <= 1'b0;
    end else begin
      soft_init_q <= wr_trig && word[sdc_pkg::SOFT_KEY_MSB:0] == sdc_pkg::SOFT_RESET_KEY;
    end
  end

  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 1'b0;
    end else if (soft_init_q) begin
      mode_q <= 1'b0;
    end else if (wr_mode) begin
      mode_q <= word[sdc_pkg::UPDATE_MODE_BIT];
    end
  end

  // code_valid_q low means the output shows the level default, which tracks level_q
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      buffer_q <= 16'h0000;
      active_q <= 16'h0000;
      code_valid_q <= 1'b0;
      code_q <= 16'h0000;
    end else begin
      if (soft_init_q) begin
        code_valid_q <= 1'b0;
      end else if (wr_code) begin
        buffer_q <= word;
        if (!mode_q) begin
          active_q <= word;
          code_valid_q <= 1'b1;
        end
      end else if (load_now) begin
        active_q <= buf_wr_q ? buffer_q : default_code(level_q);
        code_valid_q <= 1'b1;
      end
      code_q <= code_valid_q ? active_q : default_code(level_q);
    end
  end

  // out_live_q low: no edge yet since reset, so the pin-selected default drives the output
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      out_live_q <= 1'b0;
    end else begin
      out_live_q <= 1'b1;
    end
  end
  // reset forces the default at once, without waiting for a clock edge
  assign output_code = out_live_q ? code_q : default_code(rst_n ? level_q : reset_level_select);

  // a buffer never written holds the default
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      buf_wr_q <= 1'b0;
    end else if (soft_init_q) begin
      buf_wr_q <= 1'b0;
    end else if (wr_code) begin
      buf_wr_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // initialisation delay; ready tells the host link may run
  // ------------------------------------------------------------
  logic [$clog2(sdc_pkg::INIT_WAIT_CYC+1)-1:0] wait_q;
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= '0;
    end else if (soft_init_q) begin
      wait_q <= '0;
    end else if (wait_q != ($clog2(sdc_pkg::INIT_WAIT_CYC+1))'(sdc_pkg::INIT_WAIT_CYC)) begin
      wait_q <= wait_q + 1'b1;
    end
  end
  assign ready = wait_q == ($clog2(sdc_pkg::INIT_WAIT_CYC+1))'(sdc_pkg::INIT_WAIT_CYC);
  // no serial output exists on this end
endmodule // sdc_device

// ===== logic/sdc_pkg.sv
// sdc_pkg: constants shared by both ends of the three-wire converter write link.
// assumes a 200 MHz pclk on both ends.
package sdc_pkg;
  // ------------------------------------------------------------
  // frame layout
  // ------------------------------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int ADDR_MSB = 23;
  localparam int ADDR_LSB = 16;
  localparam int DATA_W = 16;
  // ------------------------------------------------------------
  // device register addresses (command byte) and fields
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_NO_EFFECT = 8'h00;
  localparam logic [7:0] ADDR_UPDATE_MODE = 8'h02;
  localparam logic [7:0] ADDR_TRIGGER = 8'h05;
  localparam logic [7:0] ADDR_OUTPUT_CODE = 8'h08;
  localparam int UPDATE_MODE_BIT = 0;
  localparam int LOAD_TRIGGER_BIT = 4;
  localparam int SOFT_KEY_MSB = 3;
  localparam logic [3:0] SOFT_RESET_KEY = 4'ha;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;
  // ------------------------------------------------------------
  // host apb registers (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] HOST_FRAME_OFS = 8'h00;
  localparam logic [7:0] HOST_STATUS_OFS = 8'h04;
  localparam logic [7:0] HOST_CTRL_OFS = 8'h08;
  localparam logic [7:0] HOST_DIV_OFS = 8'h0c;
  localparam logic [15:0] HOST_DIV_RESET = 16'h0004;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int INIT_WAIT_US = 250;
  localparam int INIT_WAIT_CYC = INIT_WAIT_US * CLK_MHZ;
  localparam int SEL_HIGH_NS = 160;
  localparam int SEL_HIGH_CYC = (SEL_HIGH_NS * CLK_MHZ + 999) / 1000;
endpackage

// ===== logic/sdc_link_if.sv
// sdc_link_if: the three write-only wires between host and converter.
// assumes both ends share pclk; the device never drives back.
`timescale 1ns/1ps
interface sdc_link_if;
  logic frame_select_n;
  logic shift_clock;
  logic serial_input;
  modport host (output frame_select_n, output shift_clock, output serial_input);
  modport device (input frame_select_n, input shift_clock, input serial_input);
endinterface // sdc_link_if

// ===== logic/sdc_host.sv
// sdc_host: apb-driven serial master that sends 24-bit frames to the converter.
// assumes an apb master on pclk; the device end shares pclk.
`timescale 1ns/1ps
module sdc_host #(
  parameter int INIT_WAIT = sdc_pkg::INIT_WAIT_CYC
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device reset pin
  output logic reset_pin_n,
  // serial link
  sdc_link_if.host link
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SDC_IDLE = 3'b001,
    SDC_SHIFT = 3'b010,
    SDC_GAP = 3'b100
  } sdc_state_t;
  sdc_state_t st_q;
  logic [23:0] data_q;
  logic [4:0] bits_q;
  logic [15:0] div_q;
  logic [15:0] divc_q;
  logic phase_q;
  logic [31:0] wait_q;
  logic [7:0] gap_q;
  logic rst_pin_q;
  logic tick;
  logic acc;
  logic start;
  logic busy;
  assign acc = psel & penable;
  assign pready = 1'b1;
  assign busy = st_q != SDC_IDLE;
  // the wait counter clears one edge after the pin falls, so the pin level gates start as well
  assign start = acc && pwrite && paddr == sdc_pkg::HOST_FRAME_OFS && !busy && wait_q == INIT_WAIT &&
                 rst_pin_q;
  assign pslverr = acc && !(paddr == sdc_pkg::HOST_FRAME_OFS || paddr == sdc_pkg::HOST_STATUS_OFS ||
                            paddr == sdc_pkg::HOST_CTRL_OFS || paddr == sdc_pkg::HOST_DIV_OFS);
  assign tick = divc_q == 16'h0000;
  assign reset_pin_n = rst_pin_q;

  always_comb begin
    prdata = 32'h0000_0000;
    if (paddr == sdc_pkg::HOST_STATUS_OFS) begin
      prdata = {30'h0000_0000, wait_q == INIT_WAIT, busy};
    end else if (paddr == sdc_pkg::HOST_CTRL_OFS) begin
      prdata = {31'h0000_0000, rst_pin_q};
    end else if (paddr == sdc_pkg::HOST_DIV_OFS) begin
      prdata = {16'h0000, div_q};
    end
  end

  // ------------------------------------------------------------
  // control registers; reset pin and 250 us wait
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_pin_q <= 1'b1;
      div_q <= sdc_pkg::HOST_DIV_RESET;
      wait_q <= 32'h0000_0000;
    end else begin
      if (acc && pwrite && paddr == sdc_pkg::HOST_CTRL_OFS && !busy) begin
        rst_pin_q <= pwdata[0];
      end
      if (acc && pwrite && paddr == sdc_pkg::HOST_DIV_OFS && pwdata[15:0] != 16'h0000) begin
        div_q <= pwdata[15:0];
      end
      if (!rst_pin_q || (start && pwdata[sdc_pkg::ADDR_MSB:sdc_pkg::ADDR_LSB] == sdc_pkg::ADDR_TRIGGER &&
                         pwdata[sdc_pkg::SOFT_KEY_MSB:0] == sdc_pkg::SOFT_RESET_KEY)) begin
        wait_q <= 32'h0000_0000;
      end else if (wait_q != INIT_WAIT) begin
        wait_q <= wait_q + 32'h0000_0001;
      end
    end
  end

  // ------------------------------------------------------------
  // frame engine: clock idles high, data changes on rise, device takes it on fall
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= SDC_IDLE;
      data_q <= 24'h00_0000;
      bits_q <= 5'h00;
      divc_q <= 16'h0000;
      phase_q <= 1'b0;
      gap_q <= 8'h00;
      link.frame_select_n <= 1'b1;
      link.shift_clock <= 1'b1;
      link.serial_input <= 1'b0;
    end else begin
      divc_q <= tick ? div_q - 16'h0001 : divc_q - 16'h0001;
      unique case (st_q)
        SDC_IDLE: begin
          if (start) begin
            data_q <= pwdata[23:0];
            bits_q <= 5'h00;
            phase_q <= 1'b0;
            link.frame_select_n <= 1'b0;
            link.serial_input <= pwdata[23];
            st_q <= SDC_SHIFT;
          end
        end
        SDC_SHIFT: begin
          if (tick) begin
            phase_q <= ~phase_q;
            if (!phase_q) begin
              link.shift_clock <= 1'b0;
              bits_q <= bits_q + 5'h01;
            end else if (bits_q == 5'(sdc_pkg::FRAME_BITS)) begin
              link.shift_clock <= 1'b1;
              link.frame_select_n <= 1'b1;
              gap_q <= 8'(sdc_pkg::SEL_HIGH_CYC);
              st_q <= SDC_GAP;
            end else begin
              link.shift_clock <= 1'b1;
              data_q <= {data_q[22:0], 1'b0};
              link.serial_input <= data_q[22];
            end
          end
        end
        SDC_GAP: begin
          gap_q <= gap_q - 8'h01;
          if (gap_q == 8'h01) begin
            st_q <= SDC_IDLE;
          end
        end
        default: st_q <= SDC_IDLE;
      endcase
    end
  end
endmodule // sdc_host

// ===== bench/sdc_link_properties.sv
// sdc_link_properties: concurrent checks on the host-to-converter link and converter outputs.
// assumes one pclk domain and presetn as power-up reset; instantiated beside the link interface.
`timescale 1ns/1ps
module sdc_link_properties (
  // clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reset_pin_n,
  input wire logic reset_level_select,
  // link wires
  input wire logic frame_select_n,
  input wire logic shift_clock,
  // converter outputs
  input wire logic [15:0] output_code,
  input wire logic ready
);
  localparam int READY_MIN = 49990;
  logic clk_prev_q;
  logic sel_prev_q;
  logic [4:0] falls_q;
  logic [3:0] since_q;
  logic [16:0] high_cnt_q;
  // ------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------
  // previous link levels start at idle high so reset leaves no false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev_q <= 1'b1;
      sel_prev_q <= 1'b1;
    end else begin
      clk_prev_q <= shift_clock;
      sel_prev_q <= frame_select_n;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      falls_q <= 5'd0;
    end else if (frame_select_n) begin
      falls_q <= 5'd0;
    end else if (clk_prev_q && !shift_clock && falls_q != 5'd31) begin
      falls_q <= falls_q + 5'd1;
    end
  end
  // output may only move a few cycles after a frame ends or a reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_q <= 4'd0;
    end else if (!reset_pin_n || (frame_select_n && !sel_prev_q)) begin
      since_q <= 4'd0;
    end else if (since_q != 4'd15) begin
      since_q <= since_q + 4'd1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_cnt_q <= 17'd0;
    end else if (!reset_pin_n) begin
      high_cnt_q <= 17'd0;
    end else if (high_cnt_q != 17'h1_ffff) begin
      high_cnt_q <= high_cnt_q + 17'd1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_frame_fall_count: assert property ($rose(frame_select_n) |-> falls_q == 5'd24)
    else $error("frame ended without exactly 24 falling shift clock edges");
  a_out_after_frame: assert property ($changed(output_code) && reset_pin_n |-> since_q < 4'd6)
    else $error("output code moved without a frame end or reset");
  a_reset_default: assert property ($rose(reset_pin_n) |-> ##[1:2]
      output_code == (reset_level_select ? sdc_pkg::CODE_MID : sdc_pkg::CODE_ZERO))
    else $error("output not at default after reset pin");
  a_clk_idle_high: assert property (frame_select_n && $past(frame_select_n) |-> shift_clock)
    else $error("shift clock not idle high outside frame");
  a_frame_starts_high: assert property ($fell(frame_select_n) |-> shift_clock)
    else $error("frame began with shift clock low");
  a_sel_gap_hold: assert property ($rose(frame_select_n) |=> frame_select_n [*8])
    else $error("frame select high time too short");
  a_ready_after_wait: assert property ($rose(ready) |-> high_cnt_q >= READY_MIN)
    else $error("ready rose before the initialisation wait");
  a_no_frame_in_reset: assert property (!reset_pin_n |-> frame_select_n)
    else $error("frame sent while reset pin low");
endmodule // sdc_link_properties

// ===== bench/tb_top.sv
// tb_top: drives the host over apb, observes the converter end across the link.
// assumes the host reset pin output feeds the converter reset pin.
`timescale 1ns/1ps
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic reset_pin_n;
  logic reset_level_select = 1'b1;
  logic [15:0] output_code;
  logic ready;
  logic [31:0] rd;
  logic err;
  int error_cnt = 0;
  int checked = 0;
  always #2.5 pclk = ~pclk;
  sdc_link_if u_sdc_link_if();
  sdc_host #(.INIT_WAIT(50)) u_sdc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin_n(reset_pin_n), .link(u_sdc_link_if));
  sdc_device u_sdc_device (.pclk(pclk), .presetn(presetn), .reset_pin_n(reset_pin_n),
    .reset_level_select(reset_level_select), .link(u_sdc_link_if), .output_code(output_code), .ready(ready));
  sdc_link_properties u_sdc_link_properties (.pclk(pclk), .presetn(presetn), .reset_pin_n(reset_pin_n),
    .reset_level_select(reset_level_select), .frame_select_n(u_sdc_link_if.frame_select_n),
    .shift_clock(u_sdc_link_if.shift_clock), .output_code(output_code), .ready(ready));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // pready is sampled at each edge; the request holds until it is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frame(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, sdc_pkg::HOST_FRAME_OFS, {8'h00, a, d});
    do apb(1'b0, sdc_pkg::HOST_STATUS_OFS, 32'h0000_0000); while (rd[0] !== 1'b0);
    repeat (8) @(posedge pclk);
  endtask
  // ------------------------------------------------------------
  // watchdog and tests
  // ------------------------------------------------------------
  initial begin
    #450000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    wait (ready === 1'b1);
    @(posedge pclk);
    chk("default code", 32'(sdc_pkg::CODE_MID), 32'(output_code));
    apb(1'b0, sdc_pkg::HOST_DIV_OFS, 32'h0000_0000);
    chk("divider reset", 32'(sdc_pkg::HOST_DIV_RESET), rd);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, 32'(err));
    frame(8'h07, 16'h4321);
    chk("unknown address", 32'(sdc_pkg::CODE_MID), 32'(output_code));
    frame(sdc_pkg::ADDR_OUTPUT_CODE, 16'h1234);
    chk("immediate write", 32'h0000_1234, 32'(output_code));
    frame(sdc_pkg::ADDR_NO_EFFECT, 16'hffff);
    chk("no effect write", 32'h0000_1234, 32'(output_code));
    frame(sdc_pkg::ADDR_UPDATE_MODE, 16'h0001);
    frame(sdc_pkg::ADDR_OUTPUT_CODE, 16'h5678);
    chk("deferred write", 32'h0000_1234, 32'(output_code));
    frame(sdc_pkg::ADDR_TRIGGER, 16'h0010);
    chk("load trigger", 32'h0000_5678, 32'(output_code));
    frame(sdc_pkg::ADDR_OUTPUT_CODE, 16'h9abc);
    chk("trigger self clear", 32'h0000_5678, 32'(output_code));
    frame(sdc_pkg::ADDR_TRIGGER, 16'h000a);
    chk("soft reset code", 32'(sdc_pkg::CODE_MID), 32'(output_code));
    chk("soft reset ready", 32'h0000_0000, 32'(ready));
    reset_level_select <= 1'b0;
    apb(1'b1, sdc_pkg::HOST_CTRL_OFS, 32'h0000_0000);
    repeat (4) @(posedge pclk);
    chk("reset pin code", 32'(sdc_pkg::CODE_ZERO), 32'(output_code));
    apb(1'b1, sdc_pkg::HOST_CTRL_OFS, 32'h0000_0001);
    repeat (4) @(posedge pclk);
    chk("code after release", 32'(sdc_pkg::CODE_ZERO), 32'(output_code));
    chk("ready after release", 32'h0000_0000, 32'(ready));
    apb(1'b0, sdc_pkg::HOST_CTRL_OFS, 32'h0000_0000);
    chk("reset pin readback", 32'h0000_0001, rd);
    apb(1'b0, sdc_pkg::HOST_STATUS_OFS, 32'h0000_0000);
    chk("host wait restart", 32'h0000_0000, rd);
    reset_level_select <= 1'b1;
    apb(1'b1, sdc_pkg::HOST_CTRL_OFS, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk("reset pin midscale", 32'(sdc_pkg::CODE_MID), 32'(output_code));
    apb(1'b1, sdc_pkg::HOST_CTRL_OFS, 32'h0000_0001);
    repeat (60) @(posedge pclk);
    chk("midscale after release", 32'(sdc_pkg::CODE_MID), 32'(output_code));
    apb(1'b0, sdc_pkg::HOST_STATUS_OFS, 32'h0000_0000);
    chk("host wait done", 32'h0000_0002, rd);
    end_of_test();
  end
endmodule // tb_top
